// >>> rtl/dsl_host.sv
`timescale 1ns/1ps
module dsl_host #(
    parameter int HALF = dsl_pkg::DSL_HALF_CYCLES,
    parameter int GAP = dsl_pkg::DSL_GAP_CYCLES,
    parameter int PULSE = dsl_pkg::DSL_PULSE_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET,
    dsl_link_if.host LINK,
    input wire logic START,
    input wire logic LONG,
    input wire logic [dsl_pkg::DSL_WORD_W-1:0] TX_WORD,
    input wire logic LOAD_REQ,
    input wire logic CLEAR_REQ,
    output logic BUSY,
    output logic DONE,
    output logic [dsl_pkg::DSL_WORD_W-1:0] RX_WORD,
    output logic FAULT
);
    import dsl_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_LOW = 3'h1,
        S_HIGH = 3'h2,
        S_GAP = 3'h3,
        S_PULSE = 3'h4
    } dsl_hstate_t;

    localparam logic [7:0] HALF_LD = DSL_TIMER_W'(HALF - 1);
    localparam logic [7:0] GAP_LD = DSL_TIMER_W'(GAP - 1);
    localparam logic [7:0] PULSE_LD = DSL_TIMER_W'(PULSE - 1);

    // synchronise the two returning lines: data out and fault
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] lines;
    assign lines = {LINK.fault_n_line, LINK.sdo_line};
    genvar gi;
    generate
        for (gi = 0; gi < DSL_SYNC_STAGES; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    sync1_ff[gi] <= 1'b1;
                    sync2_ff[gi] <= 1'b1;
                end else begin
                    sync1_ff[gi] <= lines[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    dsl_hstate_t state_ff, nxt_state;
    logic [DSL_TIMER_W-1:0] timer_ff, nxt_timer;
    logic [DSL_CNT_W-1:0] bits_ff, nxt_bits;
    logic [DSL_WORD_W-1:0] tx_ff, nxt_tx;
    logic [DSL_WORD_W-1:0] rx_ff, nxt_rx;
    logic [DSL_WORD_W-1:0] rxo_ff, nxt_rxo;
    logic sck_ff, nxt_sck;
    logic cs_n_ff, nxt_cs_n;
    logic sdi_ff, nxt_sdi;
    logic upd_n_ff, nxt_upd_n;
    logic done_ff, nxt_done;

    // frame sequencer: serial clock made by dividing CLK
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_bits = bits_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_rxo = rxo_ff;
        nxt_sck = sck_ff;
        nxt_cs_n = cs_n_ff;
        nxt_sdi = sdi_ff;
        nxt_upd_n = upd_n_ff;
        nxt_done = 1'b0;
        if (timer_ff != DSL_TIMER_ZERO) begin
            nxt_timer = timer_ff - 8'h01;
        end
        case (state_ff)
            S_IDLE: begin
                if (START) begin
                    nxt_cs_n = 1'b0;
                    nxt_upd_n = ~LOAD_REQ;
                    nxt_tx = LONG ? TX_WORD : {TX_WORD[DSL_SHORT_LEN-1:0], DSL_PAD_ZERO};
                    nxt_sdi = LONG ? TX_WORD[DSL_WORD_W-1] : TX_WORD[DSL_SHORT_LEN-1];
                    nxt_bits = LONG ? DSL_LONG_LEN : DSL_SHORT_LEN;
                    nxt_rx = DSL_WORD_ZERO;
                    nxt_timer = HALF_LD;
                    nxt_state = S_LOW;
                end else if (LOAD_REQ) begin
                    nxt_upd_n = 1'b0;
                    nxt_timer = PULSE_LD;
                    nxt_state = S_PULSE;
                end
            end
            S_LOW: begin
                if (timer_ff == DSL_TIMER_ZERO) begin
                    nxt_rx = {rx_ff[DSL_WORD_W-2:0], sync2_ff[0]};
                    nxt_sck = 1'b1;
                    nxt_bits = bits_ff - DSL_CNT_ONE;
                    nxt_timer = HALF_LD;
                    nxt_state = S_HIGH;
                end
            end
            S_HIGH: begin
                if (timer_ff == DSL_TIMER_ZERO) begin
                    nxt_sck = 1'b0;
                    nxt_timer = HALF_LD;
                    if (bits_ff == DSL_CNT_ZERO) begin
                        nxt_state = S_GAP;
                        nxt_timer = GAP_LD;
                    end else begin
                        nxt_tx = {tx_ff[DSL_WORD_W-2:0], 1'b0};
                        nxt_sdi = tx_ff[DSL_WORD_W-2];
                        nxt_state = S_LOW;
                    end
                end
            end
            S_GAP: begin
                nxt_cs_n = 1'b1;
                if (timer_ff == DSL_TIMER_ZERO) begin
                    nxt_done = 1'b1;
                    nxt_upd_n = 1'b1;
                    nxt_rxo = rx_ff;
                    nxt_state = S_IDLE;
                end
            end
            S_PULSE: begin
                if (timer_ff == DSL_TIMER_ZERO) begin
                    nxt_upd_n = 1'b1;
                    nxt_timer = GAP_LD;
                    nxt_state = S_GAP;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // sequencer registers; update line rests high when unused
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_ff <= S_IDLE;
            timer_ff <= DSL_TIMER_ZERO;
            bits_ff <= DSL_CNT_ZERO;
            tx_ff <= DSL_WORD_ZERO;
            rx_ff <= DSL_WORD_ZERO;
            rxo_ff <= DSL_WORD_ZERO;
            sck_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            sdi_ff <= 1'b0;
            upd_n_ff <= 1'b1;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            bits_ff <= nxt_bits;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            rxo_ff <= nxt_rxo;
            sck_ff <= nxt_sck;
            cs_n_ff <= nxt_cs_n;
            sdi_ff <= nxt_sdi;
            upd_n_ff <= nxt_upd_n;
            done_ff <= nxt_done;
        end
    end

    // registered status and clear line
    logic busy_ff;
    logic clr_n_ff;
    logic fault_ff;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            busy_ff <= 1'b0;
            clr_n_ff <= 1'b1;
            fault_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != S_IDLE);
            clr_n_ff <= ~CLEAR_REQ;
            fault_ff <= ~sync2_ff[1];
        end
    end

    assign LINK.sck = sck_ff;
    assign LINK.select_and_load_n = cs_n_ff;
    assign LINK.sdi = sdi_ff;
    assign LINK.async_update_n = upd_n_ff;
    assign LINK.async_clear_n = clr_n_ff;
    assign BUSY = busy_ff;
    assign DONE = done_ff;
    assign RX_WORD = rxo_ff;
    assign FAULT = fault_ff;
endmodule // dsl_host

// >>> rtl/dsl_pkg.sv
package dsl_pkg;
    // channel and word geometry
    localparam int DSL_CHANNELS = 8;
    localparam int DSL_CODE_W = 16;
    localparam int DSL_SPAN_W = 4;
    localparam int DSL_WORD_W = 32;
    localparam int DSL_CNT_W = 6;
    localparam int DSL_CH_IDX_W = 3;
    // frame lengths in bits
    localparam logic [5:0] DSL_SHORT_LEN = 6'h18;
    localparam logic [5:0] DSL_LONG_LEN = 6'h20;
    localparam logic [5:0] DSL_CNT_ONE = 6'h01;
    localparam logic [5:0] DSL_CNT_MAX = 6'h21;
    localparam logic [5:0] DSL_CNT_ZERO = 6'h00;
    // command word field positions (low 24 bits of the shift register)
    localparam int DSL_CMD_LSB = 20;
    localparam int DSL_ADDR_LSB = 16;
    localparam int DSL_DATA_LSB = 0;
    localparam int DSL_CMD_W = 4;
    localparam int DSL_ADDR_W = 4;
    localparam int DSL_PAD_W = 8;
    localparam int DSL_ADDR_HI = 3;
    // command codes
    localparam logic [3:0] DSL_CMD_WRITE = 4'h0;
    localparam logic [3:0] DSL_CMD_UPDATE = 4'h1;
    localparam logic [3:0] DSL_CMD_WRITE_UPDATE = 4'h2;
    localparam logic [3:0] DSL_CMD_SPAN = 4'h6;
    localparam logic [3:0] DSL_CMD_UPDATE_ALL = 4'h8;
    localparam logic [3:0] DSL_CMD_NOP = 4'hF;
    // reset and clear values
    localparam logic [15:0] DSL_ZERO_CODE = 16'h0000;
    localparam logic [3:0] DSL_SPAN_0_5V = 4'h0;
    localparam logic [31:0] DSL_WORD_ZERO = 32'h00000000;
    localparam logic [7:0] DSL_PAD_ZERO = 8'h00;
    // pin synchroniser
    localparam int DSL_SYNC_STAGES = 2;
    // link timing: clock rate and fastest serial clock
    localparam int DSL_CLK_MHZ = 100;
    localparam int DSL_SCK_MAX_MHZ = 50;
    localparam int DSL_HALF_MIN = (DSL_CLK_MHZ + 2 * DSL_SCK_MAX_MHZ - 1) / (2 * DSL_SCK_MAX_MHZ);
    // host defaults in clock cycles
    localparam int DSL_HALF_CYCLES = 4;
    localparam int DSL_GAP_CYCLES = 8;
    localparam int DSL_PULSE_CYCLES = 4;
    localparam int DSL_TIMER_W = 8;
    localparam logic [7:0] DSL_TIMER_ZERO = 8'h00;
endpackage

// >>> rtl/dsl_link_if.sv
`timescale 1ns/1ps
interface dsl_link_if;
    logic sck;
    logic select_and_load_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic async_update_n;
    logic async_clear_n;
    logic fault_oe;
    logic sdo_line;
    logic fault_n_line;

    // wire levels: released lines read high through the pull-up
    assign sdo_line = sdo_oe ? sdo : 1'b1;
    assign fault_n_line = ~fault_oe;

    modport device (
        input sck,
        input select_and_load_n,
        input sdi,
        input async_update_n,
        input async_clear_n,
        output sdo,
        output sdo_oe,
        output fault_oe
    );

    modport host (
        output sck,
        output select_and_load_n,
        output sdi,
        output async_update_n,
        output async_clear_n,
        input sdo_line,
        input fault_n_line
    );
endinterface

// >>> rtl/dsl_device.sv
`timescale 1ns/1ps
// How it works
// - shift input bits only while select low
// - select rising stops shifting, executes command
// - input bit sampled on rising serial clock
// - frames of 24 or 32 bits accepted
// - output bit changes on falling serial clock
// - output released while select is high
// - update falling edge with select high loads all channels
// - update low: select rising loads all
// - update tied high: only commands load
// - bad frame drives fault until next rising
// - clear forces zero code, default span
module dsl_device (
    input wire logic CLK,
    input wire logic RESET,
    dsl_link_if.device LINK,
    output logic [dsl_pkg::DSL_CHANNELS*dsl_pkg::DSL_CODE_W-1:0] DAC_CODE,
    output logic [dsl_pkg::DSL_CHANNELS*dsl_pkg::DSL_SPAN_W-1:0] DAC_SPAN,
    output logic FAULT,
    output logic FRAME_DONE,
    output logic [dsl_pkg::DSL_CNT_W-1:0] FRAME_LEN
);
    import dsl_pkg::*;

    // ---------------- link domain (serial clock) ----------------
    logic [DSL_WORD_W-1:0] shift_ff;
    logic [DSL_WORD_W-1:0] nxt_shift;
    logic [DSL_CNT_W-1:0] count_ff;
    logic [DSL_CNT_W-1:0] nxt_count;
    logic armed_ff;
    logic sdo_ff;

    // shift and count next values; edges with select high change nothing
    always_comb begin
        nxt_shift = shift_ff;
        nxt_count = count_ff;
        if (!LINK.select_and_load_n) begin
            nxt_shift = {shift_ff[DSL_WORD_W-2:0], LINK.sdi};
            if (armed_ff) begin
                nxt_count = DSL_CNT_ONE;
            end else if (count_ff != DSL_CNT_MAX) begin
                nxt_count = count_ff + DSL_CNT_ONE;
            end
        end
    end

    // sample on rising serial clock; contents hold once select rises
    always_ff @(posedge LINK.sck) begin
        shift_ff <= nxt_shift;
        count_ff <= nxt_count;
    end

    // armed by select high, so the next frame restarts the bit count
    always_ff @(posedge LINK.sck or posedge LINK.select_and_load_n) begin
        if (LINK.select_and_load_n) begin
            armed_ff <= 1'b1;
        end else begin
            armed_ff <= 1'b0;
        end
    end

    // output bit launched on the falling serial clock
    always_ff @(negedge LINK.sck) begin
        sdo_ff <= shift_ff[DSL_WORD_W-1];
    end

    assign LINK.sdo = sdo_ff;
    assign LINK.sdo_oe = ~LINK.select_and_load_n;

    // ---------------- system domain ----------------
    localparam int PINS = 3;
    localparam int PIN_CS = 0;
    localparam int PIN_UPD = 1;
    localparam int PIN_CLR = 2;

    logic [PINS-1:0] pins;
    logic [PINS-1:0] sync1_ff;
    logic [PINS-1:0] sync2_ff;
    logic [PINS-1:0] prev_ff;

    assign pins[PIN_CS] = LINK.select_and_load_n;
    assign pins[PIN_UPD] = LINK.async_update_n;
    assign pins[PIN_CLR] = LINK.async_clear_n;

    // two-stage synchronisers; all three pins idle high
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_sync
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    sync1_ff[gi] <= 1'b1;
                    sync2_ff[gi] <= 1'b1;
                    prev_ff[gi] <= 1'b1;
                end else begin
                    sync1_ff[gi] <= pins[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi] <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    logic cs_rise;
    logic upd_fall;
    logic upd_low;
    logic cs_high;
    logic clear_act;

    // edge and level detection on synchronised pins
    assign cs_rise = sync2_ff[PIN_CS] & ~prev_ff[PIN_CS];
    assign cs_high = sync2_ff[PIN_CS];
    assign upd_fall = ~sync2_ff[PIN_UPD] & prev_ff[PIN_UPD];
    assign upd_low = ~sync2_ff[PIN_UPD];
    assign clear_act = ~sync2_ff[PIN_CLR];

    // frame length check
    function automatic logic len_ok(input logic [DSL_CNT_W-1:0] len);
        len_ok = (len == DSL_SHORT_LEN) || (len == DSL_LONG_LEN);
    endfunction

    logic [DSL_CODE_W-1:0] input_ff [DSL_CHANNELS];
    logic [DSL_CODE_W-1:0] nxt_input [DSL_CHANNELS];
    logic [DSL_CODE_W-1:0] dac_ff [DSL_CHANNELS];
    logic [DSL_CODE_W-1:0] nxt_dac [DSL_CHANNELS];
    logic [DSL_SPAN_W-1:0] span_ff [DSL_CHANNELS];
    logic [DSL_SPAN_W-1:0] nxt_span [DSL_CHANNELS];
    logic fault_ff;
    logic nxt_fault;
    logic done_ff;
    logic nxt_done;
    logic [DSL_CNT_W-1:0] len_ff;
    logic [DSL_CNT_W-1:0] nxt_len;

    logic [DSL_CMD_W-1:0] cmd;
    logic [DSL_ADDR_W-1:0] addr;
    logic [DSL_CODE_W-1:0] data;
    logic [DSL_CH_IDX_W-1:0] ch;
    logic bad;

    // command fields; the shift register is static while select is high
    assign cmd = shift_ff[DSL_CMD_LSB +: DSL_CMD_W];
    assign addr = shift_ff[DSL_ADDR_LSB +: DSL_ADDR_W];
    assign data = shift_ff[DSL_DATA_LSB +: DSL_CODE_W];
    assign ch = addr[DSL_CH_IDX_W-1:0];

    // command execution, loads and clear
    always_comb begin
        nxt_input = input_ff;
        nxt_dac = dac_ff;
        nxt_span = span_ff;
        nxt_fault = fault_ff;
        nxt_done = 1'b0;
        nxt_len = len_ff;
        bad = !len_ok(count_ff) || addr[DSL_ADDR_HI];
        if (clear_act) begin
            for (int i = 0; i < DSL_CHANNELS; i++) begin
                nxt_input[i] = DSL_ZERO_CODE;
                nxt_dac[i] = DSL_ZERO_CODE;
                nxt_span[i] = DSL_SPAN_0_5V;
            end
        end else if (cs_rise) begin
            nxt_done = 1'b1;
            nxt_len = count_ff;
            nxt_fault = bad;
            if (!bad) begin
                case (cmd)
                    DSL_CMD_WRITE: begin
                        nxt_input[ch] = data;
                    end
                    DSL_CMD_UPDATE: begin
                        nxt_dac[ch] = input_ff[ch];
                    end
                    DSL_CMD_WRITE_UPDATE: begin
                        nxt_input[ch] = data;
                        nxt_dac[ch] = data;
                    end
                    DSL_CMD_SPAN: begin
                        nxt_span[ch] = data[DSL_SPAN_W-1:0];
                    end
                    DSL_CMD_UPDATE_ALL: begin
                        nxt_dac = input_ff;
                    end
                    default: begin
                    end
                endcase
            end
            if (upd_low) begin
                nxt_dac = nxt_input;
            end
        end else if (upd_fall && cs_high) begin
            nxt_dac = input_ff;
        end
    end

    // system-domain state registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            for (int i = 0; i < DSL_CHANNELS; i++) begin
                input_ff[i] <= DSL_ZERO_CODE;
                dac_ff[i] <= DSL_ZERO_CODE;
                span_ff[i] <= DSL_SPAN_0_5V;
            end
            fault_ff <= 1'b0;
            done_ff <= 1'b0;
            len_ff <= DSL_CNT_ZERO;
        end else begin
            input_ff <= nxt_input;
            dac_ff <= nxt_dac;
            span_ff <= nxt_span;
            fault_ff <= nxt_fault;
            done_ff <= nxt_done;
            len_ff <= nxt_len;
        end
    end

    // flatten channel registers onto the user ports
    generate
        for (gi = 0; gi < DSL_CHANNELS; gi++) begin : g_out
            assign DAC_CODE[gi*DSL_CODE_W +: DSL_CODE_W] = dac_ff[gi];
            assign DAC_SPAN[gi*DSL_SPAN_W +: DSL_SPAN_W] = span_ff[gi];
        end
    endgenerate

    assign LINK.fault_oe = fault_ff;
    assign FAULT = fault_ff;
    assign FRAME_DONE = done_ff;
    assign FRAME_LEN = len_ff;
endmodule // dsl_device

// >>> test/dsl_link_asserts.sv
`timescale 1ns/1ps
module dsl_link_asserts (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic sck,
    input wire logic select_and_load_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic async_update_n,
    input wire logic async_clear_n,
    input wire logic fault_oe,
    input wire logic sdo_line,
    input wire logic fault_n_line
);
    import dsl_pkg::*;
    logic sck_ff;
    logic nxt_sck;
    logic sel_ff;
    logic nxt_sel;
    logic err_ff;
    logic nxt_err;
    logic [DSL_CNT_W-1:0] rise_cnt_ff;
    logic [DSL_CNT_W-1:0] nxt_rise_cnt;
    logic [23:0] shift_ff;
    logic [23:0] nxt_shift;

    // shadow of the frame: bit count, last 24 bits and the expected fault verdict
    always_comb begin
        nxt_sck = sck;
        nxt_sel = select_and_load_n;
        nxt_rise_cnt = rise_cnt_ff;
        nxt_shift = shift_ff;
        nxt_err = err_ff;
        if (sel_ff && !select_and_load_n) begin
            nxt_rise_cnt = DSL_CNT_ZERO;
        end else if (!select_and_load_n && sck && !sck_ff) begin
            nxt_rise_cnt = rise_cnt_ff + DSL_CNT_ONE;
            nxt_shift = {shift_ff[22:0], sdi};
        end
        if (!sel_ff && select_and_load_n) begin
            nxt_err = shift_ff[19] || !(rise_cnt_ff == DSL_SHORT_LEN || rise_cnt_ff == DSL_LONG_LEN);
        end
    end

    // registers of the shadow
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sck_ff <= 1'b0;
            sel_ff <= 1'b1;
            err_ff <= 1'b0;
            rise_cnt_ff <= DSL_CNT_ZERO;
            shift_ff <= 24'h000000;
        end else begin
            sck_ff <= nxt_sck;
            sel_ff <= nxt_sel;
            err_ff <= nxt_err;
            rise_cnt_ff <= nxt_rise_cnt;
            shift_ff <= nxt_shift;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sdo_drive_select_a: assert property (sdo_oe == !select_and_load_n)
        else $error("serial output enable does not follow select");
    sdo_fall_only_a: assert property (sdo_oe && !$fell(sck) |-> $stable(sdo))
        else $error("serial output moved without a falling serial clock");
    sck_idle_select_a: assert property (select_and_load_n |-> !sck)
        else $error("serial clock high outside a frame");
    sdi_steady_high_a: assert property (sck |-> $stable(sdi))
        else $error("serial input changed while serial clock high");
    frame_bit_count_a: assert property ($rose(select_and_load_n) |->
        (rise_cnt_ff == DSL_SHORT_LEN || rise_cnt_ff == DSL_LONG_LEN))
        else $error("frame length is neither 24 nor 32 bits");
    fault_verdict_a: assert property ($rose(select_and_load_n) |-> ##6 (fault_oe == err_ff))
        else $error("fault output does not match the frame verdict");
    sdo_release_a: assert property (select_and_load_n |-> sdo_line)
        else $error("released serial output does not read high");
    update_pulse_width_a: assert property ($fell(async_update_n) && select_and_load_n |->
        (!async_update_n) [*4] ##1 async_update_n)
        else $error("update pulse width wrong");
    select_gap_a: assert property ($rose(select_and_load_n) |-> select_and_load_n [*5])
        else $error("select high time too short");
endmodule // dsl_link_asserts

// >>> test/dac_serial_load_interface_test.sv
`timescale 1ns/1ps
module dac_serial_load_interface_test;
    import dsl_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic long_frame = 1'b0;
    logic [DSL_WORD_W-1:0] tx_word = DSL_WORD_ZERO;
    logic load_req = 1'b0;
    logic clear_req = 1'b0;
    logic hold_upd = 1'b0;
    logic busy;
    logic done;
    logic host_fault;
    logic dev_fault;
    logic frame_done;
    logic [DSL_WORD_W-1:0] rx_word;
    logic [DSL_CHANNELS*DSL_CODE_W-1:0] dac_code;
    logic [DSL_CHANNELS*DSL_SPAN_W-1:0] dac_span;
    logic [DSL_CNT_W-1:0] frame_len;
    int fail_count = 0;
    int num_checks = 0;

    // system clock, 10 ns period
    always #5 clk = ~clk;

    // the two ends face each other across one link
    dsl_link_if dsl_link_if_i ();
    dsl_device dsl_device_i (.CLK(clk), .RESET(reset), .LINK(dsl_link_if_i.device),
        .DAC_CODE(dac_code), .DAC_SPAN(dac_span), .FAULT(dev_fault),
        .FRAME_DONE(frame_done), .FRAME_LEN(frame_len));
    dsl_host dsl_host_i (.CLK(clk), .RESET(reset), .LINK(dsl_link_if_i.host), .START(start),
        .LONG(long_frame), .TX_WORD(tx_word), .LOAD_REQ(load_req), .CLEAR_REQ(clear_req),
        .BUSY(busy), .DONE(done), .RX_WORD(rx_word), .FAULT(host_fault));
    dsl_link_asserts dsl_link_asserts_i (.CLK(clk), .RESET(reset), .sck(dsl_link_if_i.sck),
        .select_and_load_n(dsl_link_if_i.select_and_load_n), .sdi(dsl_link_if_i.sdi),
        .sdo(dsl_link_if_i.sdo), .sdo_oe(dsl_link_if_i.sdo_oe),
        .async_update_n(dsl_link_if_i.async_update_n),
        .async_clear_n(dsl_link_if_i.async_clear_n), .fault_oe(dsl_link_if_i.fault_oe),
        .sdo_line(dsl_link_if_i.sdo_line), .fault_n_line(dsl_link_if_i.fault_n_line));

    // counts a comparison and reports a mismatch
    task automatic report(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic chk_code(input int ch, input logic [DSL_CODE_W-1:0] exp);
        report(dac_code[ch*DSL_CODE_W +: DSL_CODE_W] === exp, "channel code");
    endtask

    task automatic chk_span(input int ch, input logic [DSL_SPAN_W-1:0] exp);
        report(dac_span[ch*DSL_SPAN_W +: DSL_SPAN_W] === exp, "channel span");
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        report(got === exp, what);
    endtask

    task automatic chk_word(input logic [DSL_WORD_W-1:0] exp);
        report(rx_word === exp, "returned word");
    endtask

    // one host request, frame or load pulse, then wait for its completion
    task automatic go(input logic ld);
        int n;
        int pulses;
        @(negedge clk);
        start = !ld;
        load_req = ld | hold_upd;
        @(negedge clk);
        start = 1'b0;
        load_req = 1'b0;
        chk_flag(busy, 1'b1, "busy after request");
        n = 0;
        pulses = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge clk);
            if (frame_done === 1'b1) begin
                pulses++;
            end
            n++;
        end
        report(n < 2000, "host completion");
        report(pulses == (ld ? 0 : 1), "frame end pulses");
        repeat (3) @(negedge clk);
    endtask

    // 32-bit frames carry a non-zero pad that must be ignored
    task automatic send(input logic is_long, input logic [3:0] cmd, input logic [3:0] addr,
        input logic [15:0] data);
        tx_word = {8'hC3, cmd, addr, data};
        long_frame = is_long;
        go(1'b0);
        report(frame_len === (is_long ? DSL_LONG_LEN : DSL_SHORT_LEN), "frame length");
    endtask

    // prints the counts and the verdict, then stops
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        for (int ch = 0; ch < DSL_CHANNELS; ch++) begin
            chk_code(ch, DSL_ZERO_CODE);
            chk_span(ch, DSL_SPAN_0_5V);
        end
        chk_flag(dev_fault, 1'b0, "fault after reset");
        send(1'b0, DSL_CMD_WRITE, 4'h0, 16'h1234);
        chk_code(0, DSL_ZERO_CODE);
        send(1'b0, DSL_CMD_UPDATE, 4'h0, 16'h0000);
        chk_code(0, 16'h1234);
        send(1'b1, DSL_CMD_WRITE_UPDATE, 4'h7, 16'hFFFF);
        chk_code(7, 16'hFFFF);
        send(1'b0, DSL_CMD_WRITE, 4'h3, 16'hA5A5);
        chk_word(32'h00C327FF);
        send(1'b1, DSL_CMD_WRITE, 4'h5, 16'h5A5A);
        chk_word(32'hFF03A5A5);
        chk_code(3, DSL_ZERO_CODE);
        go(1'b1);
        chk_code(3, 16'hA5A5);
        chk_code(5, 16'h5A5A);
        chk_code(0, 16'h1234);
        send(1'b0, DSL_CMD_WRITE, 4'h6, 16'h0F0F);
        send(1'b0, DSL_CMD_UPDATE_ALL, 4'h0, 16'h0000);
        chk_code(6, 16'h0F0F);
        send(1'b0, DSL_CMD_SPAN, 4'h2, 16'h0003);
        chk_span(2, 4'h3);
        send(1'b0, DSL_CMD_WRITE_UPDATE, 4'h9, 16'hDEAD);
        chk_flag(dev_fault, 1'b1, "fault after bad address");
        chk_flag(host_fault, 1'b1, "fault line after bad address");
        chk_code(1, DSL_ZERO_CODE);
        send(1'b1, DSL_CMD_NOP, 4'h0, 16'h0000);
        chk_flag(dev_fault, 1'b0, "fault after good frame");
        chk_flag(host_fault, 1'b0, "fault line after good frame");
        chk_code(7, 16'hFFFF);
        clear_req = 1'b1;
        repeat (8) @(negedge clk);
        for (int ch = 0; ch < DSL_CHANNELS; ch++) begin
            chk_code(ch, DSL_ZERO_CODE);
            chk_span(ch, DSL_SPAN_0_5V);
        end
        clear_req = 1'b0;
        repeat (4) @(negedge clk);
        hold_upd = 1'b1;
        send(1'b0, DSL_CMD_WRITE, 4'h4, 16'h4444);
        hold_upd = 1'b0;
        chk_code(4, 16'h4444);
        send(1'b0, DSL_CMD_UPDATE_ALL, 4'h0, 16'h0000);
        chk_code(3, DSL_ZERO_CODE);
        end_of_test();
    end

    // cuts a hung run short well beyond the expected length of all frames
    initial begin
        #200000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule // dac_serial_load_interface_test
